// [src/bitops_pkg.sv]
// register map, field layout, opcodes and flag positions of the bit/rotate datapath
package bitops_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_OPERAND = 8'h00;
	localparam logic [7:0] OFS_FLAGS   = 8'h04;
	localparam logic [7:0] OFS_CMD     = 8'h08;
	localparam logic [7:0] OFS_TIMING  = 8'h0C;
	localparam logic [7:0] OFS_IO_BASE = 8'h10;
	localparam int         IO_COUNT    = 4;

	// reset values
	localparam logic [7:0]  RST_OPERAND = 8'h00;
	localparam logic [7:0]  RST_FLAGS   = 8'h00;
	localparam logic [7:0]  RST_IO      = 8'h00;
	localparam logic [17:0] RST_CMD     = 18'h00000;
	localparam logic [8:0]  RST_TIMING  = 9'h000;

	// status flag positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;

	// command word fields
	localparam int CMD_OP_LSB     = 0;
	localparam int CMD_BIT_LSB    = 4;
	localparam int CMD_IOSEL_LSB  = 8;
	localparam int CMD_BASE_LSB   = 12;
	localparam int CMD_TARGET_LSB = 16;
	localparam int CMD_WIDTH      = 18;

	// timing register fields
	localparam int TIM_EXACT_BIT = 8;
	localparam logic [3:0] SRAM_EXTRA_CYCLES = 4'h1;

	// memory targets for the access timing query
	localparam logic [1:0] TGT_OTHER    = 2'h0;
	localparam logic [1:0] TGT_SRAM     = 2'h1;
	localparam logic [1:0] TGT_EXTERNAL = 2'h2;

	typedef enum logic [3:0] {
		OP_NOP        = 4'h0,
		OP_ROT_LEFT   = 4'h1,
		OP_ROT_RIGHT  = 4'h2,
		OP_ARITH_SHR  = 4'h3,
		OP_SWAP       = 4'h4,
		OP_SET_IO     = 4'h5,
		OP_CLR_IO     = 4'h6,
		OP_STORE_T    = 4'h7,
		OP_LOAD_T     = 4'h8,
		OP_SET_V      = 4'h9,
		OP_CLR_V      = 4'hA,
		OP_SET_H      = 4'hB,
		OP_CLR_H      = 4'hC,
		OP_SET_S      = 4'hD,
		OP_CLR_S      = 4'hE,
		OP_MEM_TIMING = 4'hF
	} op_e;

	typedef struct packed {
		logic [1:0] target;
		logic [3:0] base;
		logic [1:0] pad_hi;
		logic [1:0] io_sel;
		logic       spare;
		logic [2:0] bit_sel;
		op_e        op;
	} cmd_s;

	typedef struct packed {
		logic [7:0] operand;
		logic [7:0] flags;
		logic       io_we;
		logic [7:0] io_val;
		logic       tim_we;
		logic [8:0] timing;
	} result_s;

endpackage

// [src/bit_rotate_flag_datapath.sv]
// rotate/shift, bit transfer and flag datapath behind an apb register slave
`timescale 1ns/1ps
module bit_rotate_flag_datapath
	import bitops_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);

	logic [7:0]           operand_ff;
	logic [7:0]           flags_ff;
	logic [CMD_WIDTH-1:0] cmd_ff;
	logic [8:0]           timing_ff;
	logic [7:0]           io_ff [IO_COUNT];
	logic                 pready_ff;
	logic [31:0]          prdata_ff;
	logic                 pslverr_ff;

	// address decode
	wire logic setup_ph   = psel & ~penable;
	wire logic done       = psel & penable & pready_ff;
	wire logic hit_op     = (paddr == OFS_OPERAND);
	wire logic hit_fl     = (paddr == OFS_FLAGS);
	wire logic hit_cmd    = (paddr == OFS_CMD);
	wire logic hit_tim    = (paddr == OFS_TIMING);
	wire logic hit_io     = (paddr[7:4] == OFS_IO_BASE[7:4]) && (paddr[1:0] == 2'h0);
	wire logic [1:0] io_a = paddr[3:2];
	wire logic mapped     = hit_op | hit_fl | hit_cmd | hit_tim | hit_io;
	wire logic wr_ok      = done & pwrite & mapped;
	wire logic wr_cmd     = wr_ok & hit_cmd;

	wire cmd_s cmd        = cmd_s'(pwdata[CMD_WIDTH-1:0]);
	wire logic [7:0] io_cur = io_ff[cmd.io_sel];
	wire logic old_c      = flags_ff[FLG_C];

	wire logic [31:0] rd_mux =
		hit_op  ? {24'h000000, operand_ff} :
		hit_fl  ? {24'h000000, flags_ff} :
		hit_cmd ? {14'h0000, cmd_ff} :
		hit_tim ? {23'h000000, timing_ff} :
		hit_io  ? {24'h000000, io_ff[io_a]} : 32'h00000000;

	result_s res;

	always_comb begin
		logic [7:0] r;
		r = operand_ff;
		res = '{operand: operand_ff, flags: flags_ff, io_we: 1'b0, io_val: io_cur,
			tim_we: 1'b0, timing: timing_ff};
		case (cmd.op)
			OP_ROT_LEFT: begin
				r = {operand_ff[6:0], old_c};
				res.operand = r;
				res.flags[FLG_C] = operand_ff[7];
				res.flags[FLG_Z] = (r == 8'h00);
				res.flags[FLG_N] = r[7];
				res.flags[FLG_V] = r[7] ^ operand_ff[7];
				res.flags[FLG_H] = operand_ff[3];
			end
			OP_ROT_RIGHT: begin
				r = {old_c, operand_ff[7:1]};
				res.operand = r;
				res.flags[FLG_C] = operand_ff[0];
				res.flags[FLG_Z] = (r == 8'h00);
				res.flags[FLG_N] = r[7];
				res.flags[FLG_V] = r[7] ^ operand_ff[0];
			end
			OP_ARITH_SHR: begin
				r = {operand_ff[7], operand_ff[7:1]};
				res.operand = r;
				res.flags[FLG_C] = operand_ff[0];
				res.flags[FLG_Z] = (r == 8'h00);
				res.flags[FLG_N] = r[7];
				res.flags[FLG_V] = r[7] ^ operand_ff[0];
			end
			OP_SWAP: res.operand = {operand_ff[3:0], operand_ff[7:4]};
			OP_SET_IO: begin
				res.io_we = 1'b1;
				res.io_val[cmd.bit_sel] = 1'b1;
			end
			OP_CLR_IO: begin
				res.io_we = 1'b1;
				res.io_val[cmd.bit_sel] = 1'b0;
			end
			OP_STORE_T: res.flags[FLG_T] = operand_ff[cmd.bit_sel];
			OP_LOAD_T: res.operand[cmd.bit_sel] = flags_ff[FLG_T];
			OP_SET_V: res.flags[FLG_V] = 1'b1;
			OP_CLR_V: res.flags[FLG_V] = 1'b0;
			OP_SET_H: res.flags[FLG_H] = 1'b1;
			OP_CLR_H: res.flags[FLG_H] = 1'b0;
			OP_SET_S: res.flags[FLG_S] = 1'b1;
			OP_CLR_S: res.flags[FLG_S] = 1'b0;
			OP_MEM_TIMING: begin
				res.tim_we = 1'b1;
				// sram adds a cycle; external count only a lower bound
				res.timing[3:0] = (cmd.target == TGT_SRAM) ?
					4'(cmd.base + SRAM_EXTRA_CYCLES) : cmd.base;
				res.timing[TIM_EXACT_BIT] = (cmd.target != TGT_EXTERNAL);
				res.timing[7:4] = 4'h0;
			end
			default: r = operand_ff;
		endcase
	end

	wire logic [7:0] nxt_operand = wr_cmd ? res.operand :
		(wr_ok & hit_op) ? pwdata[7:0] : operand_ff;
	wire logic [7:0] nxt_flags = wr_cmd ? res.flags :
		(wr_ok & hit_fl) ? pwdata[7:0] : flags_ff;
	wire logic [8:0] nxt_timing = (wr_cmd & res.tim_we) ? res.timing : timing_ff;

	// apb handshake: answer registered in setup, taken in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph & ~mapped;
			prdata_ff  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand_ff <= RST_OPERAND;
			flags_ff   <= RST_FLAGS;
			cmd_ff     <= RST_CMD;
			timing_ff  <= RST_TIMING;
		end else begin
			operand_ff <= nxt_operand;
			flags_ff   <= nxt_flags;
			timing_ff  <= nxt_timing;
			if (wr_cmd) begin
				cmd_ff <= pwdata[CMD_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < IO_COUNT; i++) begin
				io_ff[i] <= RST_IO;
			end
		end else if (wr_cmd & res.io_we) begin
			io_ff[cmd.io_sel] <= res.io_val;
		end else if (wr_ok & hit_io) begin
			io_ff[io_a] <= pwdata[7:0];
		end
	end

	assign pready  = pready_ff;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	// helper state for assertions
	logic [7:0] prev_op_ff;
	logic [7:0] prev_fl_ff;
	logic [7:0] prev_io_ff;
	cmd_s       prev_cmd_ff;
	logic       prev_exec_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_op_ff   <= RST_OPERAND;
			prev_fl_ff   <= RST_FLAGS;
			prev_io_ff   <= RST_IO;
			prev_cmd_ff  <= cmd_s'(RST_CMD);
			prev_exec_ff <= 1'b0;
		end else begin
			prev_op_ff   <= operand_ff;
			prev_fl_ff   <= flags_ff;
			prev_io_ff   <= io_cur;
			prev_cmd_ff  <= cmd;
			prev_exec_ff <= wr_cmd;
		end
	end

	wire logic ex_rot_left = prev_exec_ff && prev_cmd_ff.op == OP_ROT_LEFT;

	a_left_rotate: assert property (@(posedge pclk) disable iff (!presetn)
		ex_rot_left |-> operand_ff == {prev_op_ff[6:0], prev_fl_ff[FLG_C]}
			&& flags_ff[FLG_C] == prev_op_ff[7] && flags_ff[FLG_H] == prev_op_ff[3]
			&& flags_ff[FLG_S] == prev_fl_ff[FLG_S])
		else $error("rotate left result or flags wrong");

	// zero, negative and overflow follow the new value and new carry
	a_left_flags: assert property (@(posedge pclk) disable iff (!presetn)
		ex_rot_left |-> flags_ff[FLG_Z] == (operand_ff == 8'h00)
			&& flags_ff[FLG_N] == operand_ff[7]
			&& flags_ff[FLG_V] == (operand_ff[7] ^ flags_ff[FLG_C])
			&& flags_ff[7:6] == prev_fl_ff[7:6])
		else $error("rotate left zero, negative or overflow wrong");

	a_right_rotate: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_ROT_RIGHT) |-> operand_ff ==
			{prev_fl_ff[FLG_C], prev_op_ff[7:1]} && flags_ff[FLG_C] == prev_op_ff[0]
			&& flags_ff[FLG_H] == prev_fl_ff[FLG_H] && flags_ff[FLG_Z] == (operand_ff == 8'h00))
		else $error("rotate right result or flags wrong");

	a_io_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cmd && cmd.op == OP_SET_IO) |=> io_ff[prev_cmd_ff.io_sel][prev_cmd_ff.bit_sel]
			&& flags_ff == prev_fl_ff)
		else $error("io bit not set or flags disturbed");

	a_io_bit_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cmd && cmd.op == OP_CLR_IO) |=> !io_ff[prev_cmd_ff.io_sel][prev_cmd_ff.bit_sel]
			&& flags_ff == prev_fl_ff)
		else $error("io bit not cleared or flags disturbed");

	a_store_t_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_STORE_T) |->
			flags_ff[FLG_T] == prev_op_ff[prev_cmd_ff.bit_sel]
			&& flags_ff[5:0] == prev_fl_ff[5:0] && flags_ff[7] == prev_fl_ff[7])
		else $error("transfer flag store wrong");

	a_load_t_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_LOAD_T) |->
			operand_ff[prev_cmd_ff.bit_sel] == prev_fl_ff[FLG_T] && flags_ff == prev_fl_ff)
		else $error("transfer flag load wrong");

	a_overflow_ops: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cmd && (cmd.op == OP_SET_V || cmd.op == OP_CLR_V)) |=>
			flags_ff[FLG_V] == (prev_cmd_ff.op == OP_SET_V)
			&& (flags_ff & 8'hF7) == (prev_fl_ff & 8'hF7))
		else $error("overflow flag op wrong");

	a_clear_ovf_alone: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_CLR_V) |->
			!flags_ff[FLG_V] && (flags_ff & 8'hF7) == (prev_fl_ff & 8'hF7))
		else $error("overflow clear wrong or other flags disturbed");

	a_half_signed: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cmd && cmd.op inside {OP_SET_H, OP_CLR_H, OP_SET_S, OP_CLR_S}) |=>
			((flags_ff ^ prev_fl_ff) & 8'hCF) == 8'h00)
		else $error("half carry or signed op touched other flags");

	a_half_value: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op inside {OP_SET_H, OP_CLR_H}) |->
			flags_ff[FLG_H] == (prev_cmd_ff.op == OP_SET_H) && flags_ff[FLG_S] == prev_fl_ff[FLG_S])
		else $error("half carry flag value wrong");

	a_signed_value: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op inside {OP_SET_S, OP_CLR_S}) |->
			flags_ff[FLG_S] == (prev_cmd_ff.op == OP_SET_S) && flags_ff[FLG_H] == prev_fl_ff[FLG_H])
		else $error("signed flag value wrong");

	a_sram_extra: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_MEM_TIMING) |->
			timing_ff[3:0] == prev_cmd_ff.base
				+ ((prev_cmd_ff.target == TGT_SRAM) ? SRAM_EXTRA_CYCLES : 4'h0)
			&& timing_ff[TIM_EXACT_BIT] == (prev_cmd_ff.target != TGT_EXTERNAL))
		else $error("memory timing wrong");

	a_ext_inexact: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_MEM_TIMING && prev_cmd_ff.target == TGT_EXTERNAL)
			|-> timing_ff == {1'b0, 4'h0, prev_cmd_ff.base})
		else $error("external memory count not flagged inexact");

	a_arith_shift: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_ARITH_SHR) |->
			operand_ff == {prev_op_ff[7], prev_op_ff[7:1]} && flags_ff[FLG_C] == prev_op_ff[0])
		else $error("arithmetic shift wrong");

	a_swap_nibbles: assert property (@(posedge pclk) disable iff (!presetn)
		(prev_exec_ff && prev_cmd_ff.op == OP_SWAP) |->
			operand_ff == {prev_op_ff[3:0], prev_op_ff[7:4]} && flags_ff == prev_fl_ff)
		else $error("nibble swap wrong");

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");

	a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response outside the access phase");

	a_idle_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h00000000)
		else $error("read data not zero outside a response");

	c_left_exec: cover property (@(posedge pclk) disable iff (!presetn)
		wr_cmd && cmd.op == OP_ROT_LEFT);
	c_io_set:   cover property (@(posedge pclk) disable iff (!presetn) wr_cmd && cmd.op == OP_SET_IO);
	c_sram_tim: cover property (@(posedge pclk) disable iff (!presetn)
		wr_cmd && cmd.op == OP_MEM_TIMING && cmd.target == TGT_SRAM);
	c_ext_tim:  cover property (@(posedge pclk) disable iff (!presetn)
		wr_cmd && cmd.op == OP_MEM_TIMING && cmd.target == TGT_EXTERNAL);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // bit_rotate_flag_datapath

// [testbench/bit_rotate_flag_datapath_tb.sv]
// self-checking bench for the rotate, bit transfer and flag datapath
`timescale 1ns/1ps
module bit_rotate_flag_datapath_tb
	import bitops_pkg::*;
;
	typedef struct packed {
		logic [31:0] cmd;
		logic [7:0]  opnd;
		logic [7:0]  flg;
		logic [7:0]  io;
		logic [7:0]  xo;
		logic [7:0]  xf;
		logic [7:0]  ca;
		logic [31:0] xc;
	} row_s;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	int          failures   = 0;
	int          num_checks = 0;

	// cmd, operand, flags, io preload, exp operand, exp flags, check addr, exp value
	row_s rows [24] = '{
		'{32'h00001, 8'h88, 8'h01, 8'h00, 8'h11, 8'h29, 8'h10, 32'h0},
		'{32'h00001, 8'h00, 8'h10, 8'h00, 8'h00, 8'h12, 8'h10, 32'h0},
		'{32'h00002, 8'h01, 8'h20, 8'h00, 8'h00, 8'h2B, 8'h10, 32'h0},
		'{32'h00002, 8'h80, 8'h01, 8'h00, 8'hC0, 8'h0C, 8'h10, 32'h0},
		'{32'h00003, 8'h81, 8'h00, 8'h00, 8'hC0, 8'h05, 8'h10, 32'h0},
		'{32'h00003, 8'h02, 8'h0F, 8'h00, 8'h01, 8'h00, 8'h10, 32'h0},
		'{32'h00004, 8'hA5, 8'h7F, 8'h00, 8'h5A, 8'h7F, 8'h10, 32'h0},
		'{32'h00235, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h18, 32'h08},
		'{32'h00376, 8'h3C, 8'h2A, 8'hFF, 8'h3C, 8'h2A, 8'h1C, 32'h7F},
		'{32'h00067, 8'h40, 8'h00, 8'h00, 8'h40, 8'h40, 8'h10, 32'h0},
		'{32'h00067, 8'hBF, 8'h7F, 8'h00, 8'hBF, 8'h3F, 8'h10, 32'h0},
		'{32'h00008, 8'h00, 8'h40, 8'h00, 8'h01, 8'h40, 8'h10, 32'h0},
		'{32'h00078, 8'hFF, 8'h3F, 8'h00, 8'h7F, 8'h3F, 8'h10, 32'h0},
		'{32'h00009, 8'h3C, 8'h00, 8'h00, 8'h3C, 8'h08, 8'h10, 32'h0},
		'{32'h0000A, 8'h3C, 8'h7F, 8'h00, 8'h3C, 8'h77, 8'h10, 32'h0},
		'{32'h0000B, 8'h3C, 8'h00, 8'h00, 8'h3C, 8'h20, 8'h10, 32'h0},
		'{32'h0000C, 8'h3C, 8'h7F, 8'h00, 8'h3C, 8'h5F, 8'h10, 32'h0},
		'{32'h0000D, 8'h3C, 8'h00, 8'h00, 8'h3C, 8'h10, 8'h10, 32'h0},
		'{32'h0000E, 8'h3C, 8'h7F, 8'h00, 8'h3C, 8'h6F, 8'h10, 32'h0},
		'{32'h1200F, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h0C, 32'h103},
		'{32'h1F00F, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h0C, 32'h100},
		'{32'h2500F, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h0C, 32'h005},
		'{32'h0400F, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h0C, 32'h104},
		'{32'h00000, 8'h3C, 8'h55, 8'h00, 8'h3C, 8'h55, 8'h10, 32'h0}
	};

	bit_rotate_flag_datapath u_bit_rotate_flag_datapath (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr)
	);

	always #2 pclk = ~pclk;

	task tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask

	// called just after an edge; bb keeps psel for a following setup
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input bit bb,
		output logic [31:0] d, output logic e);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 16) begin
				failures++;
				tally_and_finish();
			end
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		if (!bb) begin
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] wd, input bit bb);
		logic [31:0] d;
		logic        e;
		xfer(1'b1, a, wd, bb, d, e);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x, input string n);
		logic [31:0] d;
		logic        e;
		xfer(1'b0, a, 32'h0, 1'b0, d, e);
		chk(n, x, d);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		tally_and_finish();
	end

	initial begin
		row_s        r;
		logic [31:0] d;
		logic        e;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 24; i++) begin
			r = rows[i];
			wr(OFS_OPERAND, {24'h0, r.opnd}, 1'b0);
			wr(OFS_FLAGS, {24'h0, r.flg}, 1'b0);
			wr(OFS_IO_BASE + {4'h0, r.cmd[9:8], 2'b00}, {24'h0, r.io}, 1'b0);
			wr(OFS_CMD, r.cmd, 1'b0);
			rd(OFS_OPERAND, {24'h0, r.xo}, $sformatf("operand row %0d", i));
			rd(OFS_FLAGS, {24'h0, r.xf}, $sformatf("flags row %0d", i));
			rd(r.ca, r.xc, $sformatf("target row %0d", i));
		end
		// back-to-back rotates, carry chained through
		wr(OFS_FLAGS, 32'h0, 1'b1);
		wr(OFS_OPERAND, 32'h81, 1'b1);
		wr(OFS_CMD, 32'h1, 1'b1);
		wr(OFS_CMD, 32'h1, 1'b0);
		rd(OFS_OPERAND, 32'h05, "operand back to back");
		rd(OFS_FLAGS, 32'h00, "flags back to back");
		// unmapped accesses refused, nothing disturbed
		xfer(1'b0, 8'h20, 32'h0, 1'b0, d, e);
		chk("unmapped read data", 32'h0, d);
		chk("unmapped read error", 32'h1, {31'h0, e});
		xfer(1'b1, 8'h24, 32'hFF, 1'b0, d, e);
		chk("unmapped write error", 32'h1, {31'h0, e});
		xfer(1'b0, OFS_OPERAND, 32'h0, 1'b0, d, e);
		chk("mapped read error", 32'h0, {31'h0, e});
		chk("operand after unmapped", 32'h05, d);
		// reset in mid-run returns every register to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 32; a += 4)
			rd(a[7:0], 32'h0, $sformatf("reset value at %h", a));
		tally_and_finish();
	end
endmodule // bit_rotate_flag_datapath_tb
